/* rtl/spisc_top.sv */
// Serial port block: byte SPI engine (master/slave) and I2C pin-control master/slave status.
// Assumes APB from the core clock; serial pins are asynchronous and pass two flops first.
//
// Functional notes
// - Master write to data starts eight clocks
// - Master bit rate from two select bits
// - Slave-select pin ignored in master mode
// - Master shifts MOSI, samples MISO each period
// - Eight clocks: set flag, latch received byte
// - Slave preloads byte, shifts on incoming clock
// - Slave end: eighth clock or select high
// - I2C shares MOSI and clock pins
// - I2C only when SPI off or rerouted
// - I2C hardware slave, software master
// - Bit 7 data level when enable set
// - Bit 6 selects data pin direction
// - Bit 5 drives clock pin level
// - Bit 4 latches data on clock rise
// - Bit 3 selects master or slave role
// - Stop interrupt only when bit 7 set
// - General call sets sticky bit 6
// - Bits 5:4 report interrupt source code
// - Polarity bit sets clock idle level
// - Slave mode rate bit 0 reads select
// - Data write transmits, read returns received
`timescale 1ns/1ps
module spisc_top (
   input wire logic I_REF_CLK,            // Core clock, 20 MHz
   input wire logic I_RST,                // Async reset, active high
   input wire logic I_PSEL,               // APB select
   input wire logic I_PENABLE,            // APB enable
   input wire logic I_PWRITE,             // APB direction
   input wire logic [7:0] I_PADDR,        // APB byte address
   input wire logic [31:0] I_PWDATA,      // APB write data
   output logic [31:0] O_PRDATA,          // APB read data
   output logic O_PREADY,                 // APB ready
   output logic O_PSLVERR,                // APB error, unmapped address
   input wire logic I_SCLK,               // Clock pin input level
   output logic O_SCLK,                   // Clock pin output level
   output logic O_SCLK_OE,                // Clock pin drive enable
   input wire logic I_MOSI,               // MOSI / I2C data pin input
   output logic O_MOSI,                   // MOSI / I2C data pin output
   output logic O_MOSI_OE,                // MOSI / I2C data drive enable
   input wire logic I_MISO,               // MISO pin input
   output logic O_MISO,                   // MISO pin output
   output logic O_MISO_OE,                // MISO drive enable
   input wire logic I_SS_N,               // Slave-select pin, active low
   output logic O_SPI_IRQ,                // Byte-done interrupt request
   output logic O_I2C_IRQ                 // I2C slave interrupt request
);
   import spisc_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         // Only the select line idles high; a high clock here would fake an edge
         meta_q <= 4'h8;
         sync_q <= 4'h8;
      end else begin
         meta_q <= {I_SS_N, I_MISO, I_MOSI, I_SCLK};
         sync_q <= meta_q;
      end
   end
   logic sck_s, mosi_s, miso_s, ss_n_s, sck_prev_q, ss_prev_q;
   assign sck_s = sync_q[0];
   assign mosi_s = sync_q[1];
   assign miso_s = sync_q[2];
   assign ss_n_s = sync_q[3];
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         sck_prev_q <= 1'b0;
         ss_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         ss_prev_q <= ss_n_s;
      end
   end

   // ****************************************
   // APB decode
   // ****************************************
   logic [7:0] sp_ctrl_q, sp_data_q, i2c_q, tx_hold_q;
   logic alt_route_q;
   logic wr, rd, mapped;
   assign wr = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd = I_PSEL & I_PENABLE & ~I_PWRITE;
   assign mapped = (I_PADDR == SPISC_OFS_I2C_CTRL) || (I_PADDR == SPISC_OFS_SP_CTRL)
      || (I_PADDR == SPISC_OFS_SP_DATA) || (I_PADDR == SPISC_OFS_CFG)
      || (I_PADDR == SPISC_OFS_SL_EVT);
   logic wr_data, wr_ctrl, wr_i2c, wr_evt;
   assign wr_data = wr && I_PADDR == SPISC_OFS_SP_DATA;
   assign wr_ctrl = wr && I_PADDR == SPISC_OFS_SP_CTRL;
   assign wr_i2c = wr && I_PADDR == SPISC_OFS_I2C_CTRL;
   assign wr_evt = wr && I_PADDR == SPISC_OFS_SL_EVT;

   logic spi_en, spi_mstr, cpol, cpha, i2c_ok, i2c_master;
   assign spi_en = sp_ctrl_q[SPISC_B_EN];
   assign spi_mstr = sp_ctrl_q[SPISC_B_MSTR];
   assign cpol = sp_ctrl_q[SPISC_B_CPOL];
   assign cpha = sp_ctrl_q[SPISC_B_CPHA];
   assign i2c_ok = ~spi_en | alt_route_q;
   assign i2c_master = i2c_q[SPISC_B_ROLE];

   // ****************************************
   // SPI engine
   // ****************************************
   spisc_state_t st_q;
   logic [7:0] shift_q;
   logic [3:0] bits_q;
   logic [3:0] div_q;
   logic sck_q, done_evt, last_q;
   logic [2:0] samp_pipe_q;
   logic [7:0] rx_sh_q;
   logic mst_samp;
   logic [3:0] half_lim;
   always_comb begin
      unique case ({sp_ctrl_q[SPISC_B_RHI], sp_ctrl_q[SPISC_B_RLO]})
         2'b00: half_lim = 4'h0;
         2'b01: half_lim = 4'h1;
         2'b10: half_lim = 4'h3;
         2'b11: half_lim = 4'h7;
      endcase
   end
   logic lead_edge, trail_edge, tick;
   assign tick = div_q == half_lim;
   // Slave edges taken from synchronised pin, polarity adjusted
   logic s_rise, s_fall;
   assign s_rise = sck_s & ~sck_prev_q;
   assign s_fall = ~sck_s & sck_prev_q;
   assign lead_edge = cpol ? s_fall : s_rise;
   assign trail_edge = cpol ? s_rise : s_fall;
   logic slave_act;
   logic slv_done;
   assign slave_act = spi_en & ~spi_mstr & ~ss_n_s;
   logic s_samp, s_shift;
   assign s_samp = slave_act & (cpha ? trail_edge : lead_edge);
   assign s_shift = slave_act & (cpha ? lead_edge : trail_edge);

   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_q <= SPISC_IDLE;
         shift_q <= 8'h00;
         bits_q <= 4'h0;
         div_q <= 4'h0;
         sck_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         unique case (st_q)
            SPISC_IDLE: begin
               div_q <= 4'h0;
               sck_q <= 1'b0;
               if (wr_data && spi_en && spi_mstr) begin
                  shift_q <= I_PWDATA[7:0];
                  bits_q <= 4'h0;
                  st_q <= SPISC_RUN;
               end else if (wr_data && spi_en) begin
                  shift_q <= I_PWDATA[7:0];
                  bits_q <= 4'h0;
               end else if (s_samp) begin
                  bits_q <= bits_q + 4'h1;
               end else if (s_shift && (!cpha || bits_q != 4'h0)) begin
                  shift_q <= {shift_q[6:0], 1'b0};
               end
               if ((!ss_n_s && ss_prev_q && !spi_mstr) || (cpha && slv_done)) begin
                  bits_q <= 4'h0;
               end
            end
            SPISC_RUN: begin
               div_q <= (tick || last_q) ? 4'h0 : div_q + 4'h1;
               if (tick && !last_q) begin
                  sck_q <= ~sck_q;
                  if (sck_q) begin
                     bits_q <= bits_q + 4'h1;
                     if (bits_q == SPISC_BITS_PER_BYTE - 4'h1) last_q <= 1'b1;
                  end
                  if (!cpha && sck_q) shift_q <= {shift_q[6:0], 1'b0};
                  if (cpha && !sck_q && bits_q != 4'h0) shift_q <= {shift_q[6:0], 1'b0};
               end
               // Wait for the delayed MISO samples to drain before finishing
               if (last_q && samp_pipe_q == 3'h0) begin
                  last_q <= 1'b0;
                  st_q <= SPISC_DONE;
               end
            end
            SPISC_DONE: begin
               sck_q <= 1'b0;
               st_q <= SPISC_IDLE;
            end
            default: st_q <= SPISC_IDLE;
         endcase
      end
   end
   // MISO sampling delayed to cover pin synchroniser and output register latency
   assign mst_samp = (st_q == SPISC_RUN) && tick && !last_q && (sck_q == cpha);
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         samp_pipe_q <= 3'h0;
         rx_sh_q <= 8'h00;
      end else begin
         samp_pipe_q <= {samp_pipe_q[1:0], mst_samp};
         if (samp_pipe_q[2]) begin
            rx_sh_q <= {rx_sh_q[6:0], miso_s};
         end else if (s_samp && st_q == SPISC_IDLE) begin
            rx_sh_q <= {rx_sh_q[6:0], mosi_s};
         end
      end
   end
   // Slave completion: eighth clock with CPHA=1, select rising with CPHA=0
   assign slv_done = spi_en & ~spi_mstr & (st_q == SPISC_IDLE) &
      (cpha ? (s_samp && bits_q == SPISC_BITS_PER_BYTE - 4'h1)
            : (ss_n_s && !ss_prev_q && bits_q == SPISC_BITS_PER_BYTE));
   assign done_evt = (st_q == SPISC_DONE) | slv_done;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         sp_ctrl_q <= SPISC_RST_SP_CTRL;
         sp_data_q <= SPISC_RST_SP_DATA;
         alt_route_q <= 1'b0;
      end else begin
         if (wr_ctrl) sp_ctrl_q[6:0] <= I_PWDATA[6:0];
         if (done_evt) sp_ctrl_q[SPISC_B_DONE] <= 1'b1;   // set wins
         else if (wr_ctrl) sp_ctrl_q[SPISC_B_DONE] <= I_PWDATA[SPISC_B_DONE];
         if (done_evt) begin
            sp_data_q <= (slv_done && cpha) ? {rx_sh_q[6:0], mosi_s} : rx_sh_q;
         end
         if (wr && I_PADDR == SPISC_OFS_CFG) alt_route_q <= I_PWDATA[0];
      end
   end

   // ****************************************
   // I2C control/status
   // ****************************************
   logic mdi_q, gc_q, sie_q;
   logic [1:0] id_q;
   logic i2c_irq_q;
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         i2c_q <= SPISC_RST_I2C_CTRL;
         mdi_q <= 1'b0;
         gc_q <= 1'b0;
         id_q <= SPISC_ID_START;
         sie_q <= 1'b0;
         i2c_irq_q <= 1'b0;
      end else begin
         if (wr_i2c) i2c_q[7:3] <= I_PWDATA[7:3];
         if (wr_i2c && !I_PWDATA[SPISC_B_ROLE]) sie_q <= I_PWDATA[SPISC_B_SIE];
         if (i2c_ok && i2c_master && !i2c_q[SPISC_B_MDE] && s_rise) begin
            mdi_q <= mosi_s;
         end
         // Slave event from the slave engine (inject register): code in 1:0, gc in 2
         if (i2c_ok && !i2c_master && wr_evt && I_PWDATA[2]) gc_q <= 1'b1;
         else if (wr_i2c && !I_PWDATA[SPISC_B_GC]) gc_q <= 1'b0;
         i2c_irq_q <= 1'b0;
         if (i2c_ok && !i2c_master && wr_evt) begin
            id_q <= I_PWDATA[1:0];
            i2c_irq_q <= (I_PWDATA[1:0] != SPISC_ID_STOP) | sie_q;
         end
      end
   end

   // ****************************************
   // Pin drive and outputs
   // ****************************************
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_SCLK <= 1'b0;
         O_SCLK_OE <= 1'b0;
         O_MOSI <= 1'b0;
         O_MOSI_OE <= 1'b0;
         O_MISO <= 1'b0;
         O_MISO_OE <= 1'b0;
         O_SPI_IRQ <= 1'b0;
         O_I2C_IRQ <= 1'b0;
      end else begin
         if (spi_en && spi_mstr && !alt_route_q) begin
            O_SCLK <= sck_q ^ cpol;
            O_SCLK_OE <= 1'b1;
            O_MOSI <= shift_q[7];
            O_MOSI_OE <= 1'b1;
         end else if (i2c_ok && i2c_master) begin
            O_SCLK <= i2c_q[SPISC_B_MCO];
            O_SCLK_OE <= 1'b1;
            O_MOSI <= i2c_q[SPISC_B_MDO];
            O_MOSI_OE <= i2c_q[SPISC_B_MDE];
         end else begin
            O_SCLK <= 1'b0;
            O_SCLK_OE <= 1'b0;
            O_MOSI <= 1'b0;
            O_MOSI_OE <= 1'b0;
         end
         O_MISO <= shift_q[7];
         O_MISO_OE <= slave_act;
         O_SPI_IRQ <= sp_ctrl_q[SPISC_B_DONE];
         O_I2C_IRQ <= i2c_irq_q;
      end
   end

   // ****************************************
   // APB read path
   // ****************************************
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (I_PADDR)
         SPISC_OFS_SP_CTRL: begin
            rd_mux = sp_ctrl_q;
            if (!spi_mstr) rd_mux[SPISC_B_RLO] = ss_n_s;
         end
         SPISC_OFS_SP_DATA: rd_mux = sp_data_q;
         SPISC_OFS_CFG: rd_mux = {7'h00, alt_route_q};
         SPISC_OFS_I2C_CTRL: begin
            if (i2c_master) rd_mux = {i2c_q[7:5], mdi_q, 1'b1, 3'h0};
            else rd_mux = {sie_q, gc_q, id_q, 1'b0, 3'h0};
         end
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PRDATA <= 32'h0000_0000;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= I_PSEL & ~I_PENABLE;
         O_PSLVERR <= I_PSEL & ~I_PENABLE & ~mapped;
         O_PRDATA <= (I_PSEL & ~I_PENABLE & ~I_PWRITE) ? {24'h000000, rd_mux} : O_PRDATA;
      end
   end
   logic unused_rd;
   assign unused_rd = rd;

   // ****************************************
   // Checks
   // ****************************************
   chk_master_done_flag: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      st_q == SPISC_DONE |=> sp_ctrl_q[SPISC_B_DONE]) else $error("done flag not set");
   chk_master_burst_start: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (st_q == SPISC_IDLE && wr_data && spi_en && spi_mstr) |=> st_q == SPISC_RUN)
      else $error("burst did not start");
   chk_burst_bounded: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      $rose(st_q == SPISC_RUN) |-> ##[16:256] st_q == SPISC_DONE)
      else $error("burst length wrong");
   chk_i2c_clock_level: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (i2c_ok && i2c_master && !(spi_en && spi_mstr)) |=> O_SCLK == $past(i2c_q[5]))
      else $error("clock pin level wrong");
   chk_i2c_data_dir: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (i2c_ok && i2c_master && !spi_en) |=> O_MOSI_OE == $past(i2c_q[6]))
      else $error("data direction wrong");
   chk_gc_sticky: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (gc_q && !wr_i2c) |=> gc_q) else $error("general call lost");
   chk_stop_masked: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (wr_evt && I_PWDATA[1:0] == SPISC_ID_STOP && !sie_q) |=> !i2c_irq_q)
      else $error("stop irq while disabled");
   chk_idle_polarity: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (st_q == SPISC_IDLE && spi_en && spi_mstr && !alt_route_q) ##1 st_q == SPISC_IDLE
      |-> O_SCLK == $past(cpol)) else $error("idle level wrong");
   chk_master_no_select: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (spi_en && spi_mstr) |=> !O_MISO_OE) else $error("select used in master mode");
   chk_i2c_pins_gated: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (spi_en && !spi_mstr && !alt_route_q) |=> !O_SCLK_OE) else $error("shared pins driven");
   chk_rx_sample_count: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      $rose(st_q == SPISC_DONE) |-> $past(bits_q) == SPISC_BITS_PER_BYTE)
      else $error("receive count wrong");
endmodule

/* common/spisc_pkg.sv */
// Package for the serial port block: register offsets, field positions, reset values.
// Assumes a 32-bit APB slave, one aligned word per register.
package spisc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] SPISC_OFS_I2C_CTRL = 8'hE8;   // i2c_control_status
   localparam logic [7:0] SPISC_OFS_SP_CTRL = 8'hF8;    // serial_periph_control
   localparam logic [7:0] SPISC_OFS_SP_DATA = 8'hF4;    // serial_periph_data
   localparam logic [7:0] SPISC_OFS_CFG = 8'hEC;        // alt_pin_route_select
   localparam logic [7:0] SPISC_OFS_SL_EVT = 8'hF0;     // i2c slave event inject
   localparam logic [7:0] SPISC_RST_I2C_CTRL = 8'h00;
   localparam logic [7:0] SPISC_RST_SP_CTRL = 8'h04;
   localparam logic [7:0] SPISC_RST_SP_DATA = 8'h00;
   // ****************************************
   // serial_periph_control fields
   // ****************************************
   localparam int SPISC_B_DONE = 7;
   localparam int SPISC_B_WCOL = 6;
   localparam int SPISC_B_EN = 5;
   localparam int SPISC_B_MSTR = 4;
   localparam int SPISC_B_CPOL = 3;
   localparam int SPISC_B_CPHA = 2;
   localparam int SPISC_B_RHI = 1;
   localparam int SPISC_B_RLO = 0;
   // ****************************************
   // i2c_control_status fields
   // ****************************************
   localparam int SPISC_B_MDO = 7;
   localparam int SPISC_B_MDE = 6;
   localparam int SPISC_B_MCO = 5;
   localparam int SPISC_B_MDI = 4;
   localparam int SPISC_B_ROLE = 3;
   localparam int SPISC_B_SIE = 7;
   localparam int SPISC_B_GC = 6;
   localparam int SPISC_B_IDH = 5;
   localparam int SPISC_B_IDL = 4;
   localparam logic [3:0] SPISC_BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] SPISC_ID_START = 2'h0;
   localparam logic [1:0] SPISC_ID_RSTART = 2'h1;
   localparam logic [1:0] SPISC_ID_DATA = 2'h2;
   localparam logic [1:0] SPISC_ID_STOP = 2'h3;
   typedef enum logic [2:0] {
      SPISC_IDLE = 3'b001,
      SPISC_RUN = 3'b010,
      SPISC_DONE = 3'b100
   } spisc_state_t;
endpackage

/* bench/spisc_peer.sv */
// Far-side peer: SPI slave while the block is master, SPI master while it is slave.
// Assumes the bench resolves each pin from the output enables.
`timescale 1ns/1ps
module spisc_peer (
   input wire logic clk,        // Core clock, paces the link
   input wire logic sclk_pin,   // Resolved clock pin
   input wire logic mosi_pin,   // Resolved MOSI / data pin
   input wire logic miso_pin,   // Resolved MISO pin
   output logic p_sclk,         // Peer clock drive
   output logic p_mosi,         // Peer MOSI / data drive
   output logic p_miso,         // Peer MISO drive
   output logic p_ss_n          // Peer select drive
);
   logic sl_en = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [7:0] rx = 8'h00;
   initial begin
      p_sclk = 1'b0;
      p_mosi = 1'b1;
      p_ss_n = 1'b1;
   end
   assign p_miso = sh[7];
   // Captures on the leading edge, presents the next bit on the trailing one
   always @(posedge sclk_pin) if (sl_en) rx <= {rx[6:0], mosi_pin};
   always @(negedge sclk_pin) if (sl_en) sh <= {sh[6:0], ~sh[0]};
   task automatic hp;
      repeat (4) @(posedge clk);
   endtask
   // Select stays low over the byte; clock is ours
   task automatic xfer(input logic cpha, input logic [7:0] tx, output logic [7:0] d);
      p_ss_n <= 1'b0;
      hp;
      for (int i = 7; i >= 0; i--) begin
         if (!cpha) p_mosi <= tx[i];
         hp;
         p_sclk <= 1'b1;
         // Reply is read just after the edge: the slave trails by its synchroniser
         if (cpha) p_mosi <= tx[i];
         else begin
            @(negedge clk);
            d[i] = miso_pin;
         end
         hp;
         p_sclk <= 1'b0;
         if (cpha) begin
            @(negedge clk);
            d[i] = miso_pin;
         end
      end
   endtask
   task automatic drop;
      p_ss_n <= 1'b1;
      p_mosi <= ~p_mosi;
   endtask
   task automatic set_data(input logic v);
      p_mosi <= v;
   endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the serial port block, APB master tasks.
// Assumes a 20 MHz core clock and the peer model beside the pins.
`timescale 1ns/1ps
module tb_top;
   import spisc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, d;
   logic prdy, perr, e_s, sclk_d, spi_irq, i2c_irq;
   logic osclk, osclk_oe, omosi, omosi_oe, omiso, omiso_oe;
   logic p_sclk, p_mosi, p_miso, p_ss_n;
   logic [7:0] rx_s;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int nrise = 0;
   int gap = 0;
   int last = 0;
   int nirq = 0;
   int n0;
   wire sclk_pin = osclk_oe ? osclk : p_sclk;
   wire mosi_pin = omosi_oe ? omosi : p_mosi;
   wire miso_pin = omiso_oe ? omiso : p_miso;
   always #25 clk = ~clk;
   spisc_top DUT (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
      .O_PSLVERR(perr), .I_SCLK(sclk_pin), .O_SCLK(osclk), .O_SCLK_OE(osclk_oe),
      .I_MOSI(mosi_pin), .O_MOSI(omosi), .O_MOSI_OE(omosi_oe), .I_MISO(miso_pin),
      .O_MISO(omiso), .O_MISO_OE(omiso_oe), .I_SS_N(p_ss_n), .O_SPI_IRQ(spi_irq),
      .O_I2C_IRQ(i2c_irq));
   spisc_peer u_peer (.clk(clk), .sclk_pin(sclk_pin), .mosi_pin(mosi_pin),
      .miso_pin(miso_pin), .p_sclk(p_sclk), .p_mosi(p_mosi), .p_miso(p_miso),
      .p_ss_n(p_ss_n));
   always @(posedge clk) begin
      cyc++;
      sclk_d <= osclk;
      if (osclk === 1'b1 && sclk_d === 1'b0) begin
         nrise++;
         gap = cyc - last;
         last = cyc;
      end
      if (i2c_irq === 1'b1) nirq++;
      if (cyc == 60000) begin
         fails++;
         final_report;
      end
   end
   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1 && k < 50) begin
         k++;
         @(posedge clk);
      end
      if (k >= 50) fails++;
      d = prd;
      e_s = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_irq;
      int k = 0;
      while (spi_irq !== 1'b1 && k < 3000) begin
         k++;
         @(posedge clk);
      end
      if (k >= 3000) fails++;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(SPISC_OFS_I2C_CTRL);
      cmp("i2c reset", SPISC_RST_I2C_CTRL, d);
      rd(SPISC_OFS_SP_CTRL);
      cmp("ctrl reset", SPISC_RST_SP_CTRL | 32'h1, d);
      rd(SPISC_OFS_SP_DATA);
      cmp("data reset", SPISC_RST_SP_DATA, d);
      rd(8'h00);
      cmp("unmapped err", 1, e_s);
      cmp("unmapped data", 0, d);
      // Master bytes at every rate, select pin left high
      for (int r = 0; r < 4; r++) begin
         u_peer.sl_en = 1'b1;
         u_peer.sh = 8'h3C ^ 8'(r);
         wr(SPISC_OFS_SP_CTRL, 32'h30 | r);
         n0 = nrise;
         wr(SPISC_OFS_SP_DATA, 32'hA5 + r);
         wait_irq;
         cmp("rises", 8, nrise - n0);
         cmp("period", 2 << r, gap);
         cmp("peer rx", 8'hA5 + r, u_peer.rx);
         rd(SPISC_OFS_SP_DATA);
         cmp("rx data", 8'h3C ^ r, d);
         rd(SPISC_OFS_SP_CTRL);
         cmp("done ctrl", 32'hB0 | r, d);
         wr(SPISC_OFS_SP_CTRL, 32'h30 | r);
         repeat (3) @(posedge clk);
         cmp("irq clear", 0, spi_irq);
      end
      u_peer.sl_en = 1'b0;
      wr(SPISC_OFS_SP_CTRL, 32'h38);
      repeat (3) @(posedge clk);
      cmp("cpol idle", 1, osclk);
      // Slave bytes, clock phase 1 then 0
      for (int c = 1; c >= 0; c--) begin
         wr(SPISC_OFS_SP_CTRL, 32'h20 | (c << 2));
         rd(SPISC_OFS_SP_CTRL);
         cmp("ss high", 1, d[0]);
         wr(SPISC_OFS_SP_DATA, 32'h5A ^ c);
         u_peer.xfer(c[0], 8'hC3 ^ 8'(c), rx_s);
         repeat (6) @(posedge clk);
         cmp("early done", c, spi_irq);
         rd(SPISC_OFS_SP_CTRL);
         cmp("ss low", 0, d[0]);
         u_peer.drop;
         repeat (6) @(posedge clk);
         cmp("slave done", 1, spi_irq);
         cmp("miso byte", 8'h5A ^ c, rx_s);
         rd(SPISC_OFS_SP_DATA);
         cmp("mosi byte", 8'hC3 ^ c, d);
         wr(SPISC_OFS_SP_CTRL, 32'h20 | (c << 2));
      end
      wr(SPISC_OFS_SP_CTRL, 32'h00);
      wr(SPISC_OFS_I2C_CTRL, 32'h6F);
      repeat (3) @(posedge clk);
      cmp("scl drive", 2'b11, {osclk_oe, osclk});
      cmp("sda drive", 2'b10, {omosi_oe, omosi});
      rd(SPISC_OFS_I2C_CTRL);
      cmp("master view", 8'h68, d);
      wr(SPISC_OFS_I2C_CTRL, 32'hE8);
      repeat (3) @(posedge clk);
      cmp("sda high", 2'b11, {omosi_oe, omosi});
      for (int v = 1; v >= 0; v--) begin
         u_peer.set_data(v[0]);
         wr(SPISC_OFS_I2C_CTRL, 32'h88);
         wr(SPISC_OFS_I2C_CTRL, 32'hA8);
         repeat (4) @(posedge clk);
         rd(SPISC_OFS_I2C_CTRL);
         cmp("data in", v, d[4]);
         cmp("sda released", 0, omosi_oe);
      end
      wr(SPISC_OFS_SP_CTRL, 32'h30);
      repeat (3) @(posedge clk);
      cmp("spi owns scl", 0, osclk);
      wr(SPISC_OFS_CFG, 32'h01);
      repeat (3) @(posedge clk);
      cmp("rerouted scl", 1, osclk);
      wr(SPISC_OFS_CFG, 32'h00);
      wr(SPISC_OFS_SP_CTRL, 32'h00);
      wr(SPISC_OFS_I2C_CTRL, 32'h80);
      for (int k = 0; k < 4; k++) begin
         n0 = nirq;
         wr(SPISC_OFS_SL_EVT, k);
         repeat (3) @(posedge clk);
         cmp("irq pulse", 1, nirq - n0);
         rd(SPISC_OFS_I2C_CTRL);
         cmp("source", 32'h80 | (k << 4), d);
      end
      wr(SPISC_OFS_I2C_CTRL, 32'h00);
      n0 = nirq;
      wr(SPISC_OFS_SL_EVT, 32'h3);
      repeat (3) @(posedge clk);
      cmp("stop masked", 0, nirq - n0);
      wr(SPISC_OFS_SL_EVT, 32'h4);
      rd(SPISC_OFS_I2C_CTRL);
      cmp("general call", 8'h40, d);
      wr(SPISC_OFS_SL_EVT, 32'h2);
      rd(SPISC_OFS_I2C_CTRL);
      cmp("gc sticky", 8'h60, d);
      wr(SPISC_OFS_I2C_CTRL, 32'h00);
      rd(SPISC_OFS_I2C_CTRL);
      cmp("gc cleared", 0, d[6]);
      final_report;
   end
endmodule
